// file: design/iopcc_regs.svh
`ifndef IOPCC_REGS_SVH
`define IOPCC_REGS_SVH
// Overview of operation
// - control field: 11 plain, 10 watchdog, 01 timing, 00 compare
// - direction bit 1 input, 0 output drive
// - polarity bit 1 non-inverted, 0 inverted
// - input pin interrupt enabled when mask is 0
// - output with mask 1 drives polarity bit
// - pin a mask 0 drives supervisor xor not polarity
// - compare register uses bits 15..0, upper read zero
// - bit 13 or compare write clears both flags
// - plain mode: pin c acts like others
// - watchdog mode: match raises reset exception
// - timing input active level sets event, captures timer
// - timing input match before event sets equal
// - timing input: either flag requests enabled interrupt
// - event may follow equal, never equal after event
// - already-active level sets event at once; 16-bit span
// - timing output match sets equal, toggles latch
// - timing output drives latch xor polarity
// - writing bit 13 as one clears toggle latch
// - compare mode match interrupts regardless of mask
// - reset sets every control bit to one
// - control register is write-only, reads zero

`define IOPCC_IDX_FUNC   2'h0
`define IOPCC_IDX_CMP    2'h1
`define IOPCC_IDX_STAT   2'h2
`define IOPCC_FUNC_RST   32'hffff_ffff
`define IOPCC_HSIZE_WORD 3'h2
`define IOPCC_F_MODE_HI  13
`define IOPCC_F_MODE_LO  12
`define IOPCC_F_DIR      2
`define IOPCC_F_POL      1
`define IOPCC_F_MASK     0
`define IOPCC_F_STRIDE   4
`define IOPCC_ST_EVENT   8
`define IOPCC_ST_EQUAL   7
`define IOPCC_ST_LVL     4
`define IOPCC_PIN_C      2
`endif

// file: design/iopcc_pkg.sv
package iopcc_pkg;
   typedef enum logic [1:0] {
      IOPCC_PLAIN_PIN_MODE         = 2'b11,
      IOPCC_WATCHDOG_MODE          = 2'b10,
      IOPCC_TIMING_MODE            = 2'b01,
      IOPCC_COMPARE_INTERRUPT_MODE = 2'b00
   } iopcc_mode_t;

   typedef struct packed {
      logic dir;
      logic pol;
      logic mask;
   } iopcc_pin_cfg_t;

   typedef struct packed {
      logic [31:0] func;
      logic [15:0] cmp;
      logic        capture_event_flag;
      logic        compare_match_flag;
      logic        toggle;
      logic        match_q;
      logic [2:0]  sync1;
      logic [2:0]  pin_level;
      logic        wr_pend;
      logic [1:0]  wr_idx;
      logic        rd_pend;
      logic [1:0]  rd_idx;
      logic        hready;
      logic [31:0] hrdata;
      logic [2:0]  pin_out;
      logic [2:0]  pin_oe;
      logic [2:0]  pin_irq;
      logic        wdog_rst;
   } iopcc_state_t;
endpackage : iopcc_pkg

// file: design/iopcc_top.sv
`timescale 1ns/1ns
`include "iopcc_regs.svh"
module iopcc_top (
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [15:0] timer_count,
   input  wire logic        supervisor_flag,
   input  wire logic [2:0]  pin_in,
   output logic      [2:0]  pin_out,
   output logic      [2:0]  pin_oe,
   output logic      [2:0]  pin_irq,
   output logic             watchdog_reset
);
   localparam iopcc_pkg::iopcc_state_t ST_RST = '{
      func:    `IOPCC_FUNC_RST,
      hready:  1'b1,
      default: '0
   };

   iopcc_pkg::iopcc_state_t   st_r;
   iopcc_pkg::iopcc_state_t   st_nxt;
   iopcc_pkg::iopcc_mode_t    mode;
   iopcc_pkg::iopcc_pin_cfg_t pc;
   iopcc_pkg::iopcc_pin_cfg_t cc;
   logic                      match;
   logic                      match_edge;
   logic                      acc;
   logic                      wr_func;
   logic                      wr_cmp;
   logic                      clr13;
   logic                      clr;
   logic                      timing_in;
   logic                      timing_out;
   logic                      ev_go;
   logic                      eq_go;
   logic                      tog_go;
   logic                      std_irq;

   function automatic iopcc_pkg::iopcc_pin_cfg_t pin_cfg(
      input logic [31:0] f,
      input int          i
   );
      int b;
      b = `IOPCC_F_STRIDE * i;
      pin_cfg.dir  = f[b + `IOPCC_F_DIR];
      pin_cfg.pol  = f[b + `IOPCC_F_POL];
      pin_cfg.mask = f[b + `IOPCC_F_MASK];
   endfunction : pin_cfg

   always_comb begin
      st_nxt = st_r;
      mode = iopcc_pkg::iopcc_mode_t'(
         st_r.func[`IOPCC_F_MODE_HI:`IOPCC_F_MODE_LO]);
      cc = pin_cfg(st_r.func, `IOPCC_PIN_C);
      pc = cc;
      std_irq = 1'b0;

      // only the second stage is looked at
      st_nxt.sync1     = pin_in;
      st_nxt.pin_level = st_r.sync1;

      // timer may hold a value for many cycles; act on first match cycle
      match          = (st_r.cmp == timer_count);
      match_edge     = match & ~st_r.match_q;
      st_nxt.match_q = match;

      // bus: writes land in data phase, reads take one wait state
      acc = hsel & htrans[1] & hready & (hsize == `IOPCC_HSIZE_WORD);
      st_nxt.wr_pend = acc & hwrite;
      st_nxt.rd_pend = acc & ~hwrite;
      st_nxt.wr_idx  = haddr[3:2];
      st_nxt.rd_idx  = haddr[3:2];
      st_nxt.hready  = ~(acc & ~hwrite);

      wr_func = st_r.wr_pend & (st_r.wr_idx == `IOPCC_IDX_FUNC);
      wr_cmp  = st_r.wr_pend & (st_r.wr_idx == `IOPCC_IDX_CMP);
      clr13   = wr_func & hwdata[`IOPCC_F_MODE_HI];
      clr     = clr13 | wr_cmp;
      if (wr_func) begin
         st_nxt.func = hwdata;
      end
      if (wr_cmp) begin
         st_nxt.cmp = hwdata[15:0];
      end

      timing_in  = (mode == iopcc_pkg::IOPCC_TIMING_MODE) & cc.dir;
      timing_out = (mode == iopcc_pkg::IOPCC_TIMING_MODE) & ~cc.dir;
      // level based, so an already-active pin fires at once
      ev_go = timing_in & (st_r.pin_level[`IOPCC_PIN_C] == cc.pol)
            & ~st_r.capture_event_flag;
      eq_go = match_edge & (
                 (timing_in & ~st_r.capture_event_flag & ~ev_go)
               | timing_out
               | (mode == iopcc_pkg::IOPCC_COMPARE_INTERRUPT_MODE)
              );
      tog_go = timing_out & match_edge;

      // hardware set beats the software clear in the same cycle
      if (clr) begin
         st_nxt.capture_event_flag = 1'b0;
         st_nxt.compare_match_flag = 1'b0;
      end
      if (ev_go) begin
         st_nxt.capture_event_flag = 1'b1;
         st_nxt.cmp = timer_count;
      end
      if (eq_go) begin
         st_nxt.compare_match_flag = 1'b1;
      end
      if (clr13) begin
         st_nxt.toggle = tog_go;
      end else if (tog_go) begin
         st_nxt.toggle = ~st_r.toggle;
      end

      st_nxt.wdog_rst = (mode == iopcc_pkg::IOPCC_WATCHDOG_MODE)
                      & match_edge;

      for (int i = 0; i < 3; i++) begin
         pc = pin_cfg(st_r.func, i);
         st_nxt.pin_oe[i] = ~pc.dir;
         // mask 0 on b and c output is reserved; treat like mask 1
         st_nxt.pin_out[i] = pc.pol;
         if (i == 0 && !pc.mask) begin
            st_nxt.pin_out[i] = supervisor_flag ^ ~pc.pol;
         end
         st_nxt.pin_irq[i] = pc.dir & ~pc.mask
                           & (st_r.pin_level[i] == pc.pol);
      end
      std_irq = st_nxt.pin_irq[`IOPCC_PIN_C];

      case (mode)
         iopcc_pkg::IOPCC_TIMING_MODE: begin
            if (cc.dir) begin
               st_nxt.pin_irq[`IOPCC_PIN_C] = ~cc.mask
                  & (st_r.capture_event_flag
                     | st_r.compare_match_flag);
            end else begin
               st_nxt.pin_irq[`IOPCC_PIN_C] = ~cc.mask
                  & st_r.compare_match_flag;
               st_nxt.pin_out[`IOPCC_PIN_C] =
                  st_r.toggle ^ cc.pol;
            end
         end
         iopcc_pkg::IOPCC_COMPARE_INTERRUPT_MODE: begin
            st_nxt.pin_irq[`IOPCC_PIN_C] =
               std_irq | st_r.compare_match_flag;
         end
         default: begin
            st_nxt.pin_irq[`IOPCC_PIN_C] = std_irq;
         end
      endcase

      if (st_r.rd_pend) begin
         case (st_r.rd_idx)
            `IOPCC_IDX_CMP: begin
               st_nxt.hrdata = {16'h0000, st_r.cmp};
            end
            `IOPCC_IDX_STAT: begin
               st_nxt.hrdata = 32'h0000_0000;
               st_nxt.hrdata[`IOPCC_ST_EVENT] = st_r.capture_event_flag;
               st_nxt.hrdata[`IOPCC_ST_EQUAL] = st_r.compare_match_flag;
               st_nxt.hrdata[`IOPCC_ST_LVL +: 3] = st_r.pin_level;
            end
            default: begin
               st_nxt.hrdata = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign hrdata         = st_r.hrdata;
   assign hreadyout      = st_r.hready;
   assign hresp          = 1'b0;
   assign pin_out        = st_r.pin_out;
   assign pin_oe         = st_r.pin_oe;
   assign pin_irq        = st_r.pin_irq;
   assign watchdog_reset = st_r.wdog_rst;

   default clocking dcb @(posedge sys_clk);
   endclocking
   default disable iff (srst);

   AST_RESET_ALL_ONES: assert property (
      $past(srst) |-> (st_r.func == `IOPCC_FUNC_RST) && !pin_oe[0]
   ) else $error("control not all ones after reset");

   AST_DIR_DRIVES_OE: assert property (
      ##1 pin_oe[1] == ~$past(st_r.func[6])
   ) else $error("pin b enable does not follow direction");

   AST_OUT_POLARITY: assert property (
      (!st_r.func[6] && st_r.func[4]) |=> pin_out[1] == $past(st_r.func[5])
   ) else $error("pin b output does not show polarity");

   AST_SUPERVISOR_OUT: assert property (
      (st_r.func[2:0] == 3'h0) |=>
         pin_out[0] == !$past(supervisor_flag)
   ) else $error("pin a supervisor drive wrong");

   AST_CMP_UPPER_ZERO: assert property (
      (st_r.rd_pend && st_r.rd_idx == `IOPCC_IDX_CMP) |=>
         hreadyout && hrdata[31:16] == 16'h0000
   ) else $error("compare read upper half not zero");

   AST_WRITE_CLEARS: assert property (
      (wr_cmp && !ev_go && !eq_go) |=>
         !st_r.capture_event_flag && !st_r.compare_match_flag
   ) else $error("compare write did not clear flags");

   AST_CAPTURE_TIME: assert property (
      ev_go |=> st_r.capture_event_flag && st_r.cmp == $past(timer_count)
   ) else $error("event capture wrong");

   AST_NO_EQUAL_AFTER_EVENT: assert property (
      (timing_in && st_r.capture_event_flag && !clr) |=>
         st_r.compare_match_flag == $past(st_r.compare_match_flag)
   ) else $error("equal flag set after event");

   AST_TOGGLE_ON_MATCH: assert property (
      (tog_go && !clr13) |=> st_r.toggle != $past(st_r.toggle)
   ) else $error("toggle latch did not toggle");

   AST_WATCHDOG_FIRES: assert property (
      (mode == iopcc_pkg::IOPCC_WATCHDOG_MODE && match_edge)
         |=> watchdog_reset ##1 !watchdog_reset
   ) else $error("watchdog reset not one pulse");

   AST_TIMER_IRQ_ANY_MASK: assert property (
      (mode == iopcc_pkg::IOPCC_COMPARE_INTERRUPT_MODE &&
       st_r.compare_match_flag) |=> pin_irq[2]
   ) else $error("compare interrupt missing");

   AST_TOGGLE_CLEAR: assert property (
      (clr13 && !tog_go) |=> !st_r.toggle
   ) else $error("toggle latch not cleared");

   COV_CAPTURE: cover property (
      timing_in && ev_go
   );
   COV_TIMEOUT: cover property (
      timing_in && eq_go ##[1:20] ev_go
   );
   COV_TOGGLE_OUT: cover property (
      tog_go ##1 pin_out[2] != $past(pin_out[2])
   );
   COV_WATCHDOG: cover property (
      watchdog_reset
   );
endmodule : iopcc_top

// file: verification/iopcc_pin_model.sv
`timescale 1ns/1ns
module iopcc_pin_model (
   input  wire logic [2:0] ext_lvl,
   input  wire logic [2:0] pin_out,
   input  wire logic [2:0] pin_oe,
   output logic      [2:0] pin_in
);
   // far side drives only where the device has let go of the pin
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext_lvl[i];
      end
   end
endmodule : iopcc_pin_model

// file: verification/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   localparam logic [31:0] A_FN = 32'h0;
   localparam logic [31:0] A_CM = 32'h4;
   localparam logic [31:0] A_ST = 32'h8;
   logic        sys_clk, srst, hsel, hwrite, hreadyout, hresp;
   logic        supervisor_flag, watchdog_reset;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize, ext_lvl, pin_in, pin_out, pin_oe, pin_irq;
   logic [15:0] timer_count;
   int          error_cnt, compares;

   iopcc_top u_iopcc_top (.sys_clk(sys_clk), .srst(srst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .timer_count(timer_count),
      .supervisor_flag(supervisor_flag), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .pin_irq(pin_irq),
      .watchdog_reset(watchdog_reset));
   iopcc_pin_model u_iopcc_pin_model (.ext_lvl(ext_lvl),
      .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic ahb(input logic w, input logic [31:0] a, d);
      @(posedge sys_clk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= w;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb

   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : wt

   // pin fields are {dir, pol, mask}; reserved bits kept at one
   function automatic logic [31:0] fv(input logic [1:0] m,
                                      input logic [2:0] c, b, a);
      return {18'h3ffff, m, 1'b1, c, 1'b1, b, 1'b1, a};
   endfunction : fv

   task automatic t_reset();
      chk(pin_oe, 3'h0);
      chk(hresp, 1'b0);
      wt(3);
      chk(pin_irq, 3'h0);
      ahb(1'b0, A_FN, 32'h0);
      chk(rd, 32'h0);
      ahb(1'b1, 32'hc, 32'hffff_ffff);
      ahb(1'b0, 32'hc, 32'h0);
      chk(rd, 32'h0);
      $display("t_reset done");
   endtask : t_reset

   task automatic t_pins();
      for (int i = 0; i < 4; i++) begin
         supervisor_flag <= i[1];
         ahb(1'b1, A_FN, fv(2'b11, {1'b0, i[0], 1'b1},
                            {1'b1, i[0], 1'b0}, {1'b0, i[0], 1'b0}));
         wt(4);
         chk(pin_oe, 3'b101);
         chk(pin_out[0], i[1] ^ !i[0]);
         chk(pin_out[2], i[0]);
         chk(pin_irq[1], i[0]);
      end
      ahb(1'b1, A_FN, fv(2'b11, 3'b111, 3'b111, 3'b111));
      wt(4);
      chk(pin_irq[1], 1'b0);
      $display("t_pins done");
   endtask : t_pins

   task automatic t_tin();
      timer_count <= 16'h0100;
      ext_lvl[2]  <= 1'b0;
      ahb(1'b1, A_CM, 32'h0000_5555);
      ahb(1'b1, A_FN, fv(2'b01, 3'b110, 3'b111, 3'b111));
      wt(4);
      chk(pin_irq[2], 1'b0);
      ext_lvl[2] <= 1'b1;
      wt(6);
      ahb(1'b0, A_ST, 32'h0);
      chk(rd[8:7], 2'b10);
      chk(pin_irq[2], 1'b1);
      ahb(1'b0, A_CM, 32'h0);
      chk(rd, 32'h0000_0100);
      ext_lvl[2] <= 1'b0;
      wt(3);
      ahb(1'b1, A_CM, 32'h0000_5555);
      ahb(1'b0, A_ST, 32'h0);
      chk(rd[8:7], 2'b00);
      ahb(1'b1, A_FN, fv(2'b11, 3'b110, 3'b111, 3'b111));
      ext_lvl[2] <= 1'b1;
      wt(4);
      ahb(1'b1, A_FN, fv(2'b01, 3'b110, 3'b111, 3'b111));
      wt(4);
      ahb(1'b0, A_ST, 32'h0);
      chk(rd[8], 1'b1);
      $display("t_tin done");
   endtask : t_tin

   task automatic t_tout();
      ahb(1'b1, A_FN, fv(2'b11, 3'b110, 3'b111, 3'b111));
      timer_count <= 16'h01ff;
      ext_lvl[2]  <= 1'b0;
      ahb(1'b1, A_CM, 32'h0000_0200);
      ahb(1'b1, A_FN, fv(2'b01, 3'b110, 3'b111, 3'b111));
      wt(2);
      timer_count <= 16'h0200;
      wt(5);
      ahb(1'b0, A_ST, 32'h0);
      chk(rd[8:7], 2'b01);
      chk(pin_irq[2], 1'b1);
      timer_count <= 16'h0234;
      ext_lvl[2]  <= 1'b1;
      wt(6);
      ahb(1'b0, A_ST, 32'h0);
      chk(rd[8:7], 2'b11);
      ahb(1'b0, A_CM, 32'h0);
      chk(rd, 32'h0000_0234);
      ahb(1'b1, A_FN, fv(2'b11, 3'b111, 3'b111, 3'b111));
      ahb(1'b0, A_ST, 32'h0);
      chk(rd[8:7], 2'b00);
      $display("t_tout done");
   endtask : t_tout

   task automatic t_tgl();
      timer_count <= 16'h0300;
      ahb(1'b1, A_CM, 32'h0000_0301);
      ahb(1'b1, A_FN, fv(2'b01, 3'b011, 3'b111, 3'b111));
      wt(3);
      chk(pin_out[2], 1'b1);
      timer_count <= 16'h0301;
      wt(5);
      chk(pin_out[2], 1'b0);
      ahb(1'b0, A_ST, 32'h0);
      chk(rd[7], 1'b1);
      // latch clear, polarity flip and plain mode in one write: no edge on pin
      ahb(1'b1, A_FN, fv(2'b11, 3'b001, 3'b111, 3'b111));
      wt(3);
      chk(pin_out[2], 1'b0);
      timer_count <= 16'h0000;
      ahb(1'b1, A_FN, fv(2'b01, 3'b011, 3'b111, 3'b111));
      wt(3);
      chk(pin_out[2], 1'b1);
      ahb(1'b1, A_FN, fv(2'b11, 3'b111, 3'b111, 3'b111));
      $display("t_tgl done");
   endtask : t_tgl

   task automatic t_wdog();
      int n;
      n = 0;
      timer_count <= 16'h0400;
      ahb(1'b1, A_CM, 32'h0000_0402);
      ahb(1'b1, A_FN, fv(2'b10, 3'b111, 3'b111, 3'b111));
      timer_count <= 16'h0401;
      wt(2);
      timer_count <= 16'h0402;
      repeat (8) begin
         @(posedge sys_clk);
         n += watchdog_reset;
      end
      chk(n, 1);
      chk(pin_oe, 3'h0);
      $display("t_wdog done");
   endtask : t_wdog

   task automatic t_cirq();
      ahb(1'b1, A_FN, fv(2'b11, 3'b111, 3'b111, 3'b111));
      timer_count <= 16'h0500;
      ahb(1'b1, A_CM, 32'h0000_0503);
      ahb(1'b1, A_FN, fv(2'b00, 3'b111, 3'b111, 3'b111));
      wt(3);
      chk(pin_irq[2], 1'b0);
      timer_count <= 16'h0503;
      wt(5);
      chk(pin_irq[2], 1'b1);
      ahb(1'b1, A_FN, fv(2'b11, 3'b111, 3'b111, 3'b111));
      wt(3);
      chk(pin_irq[2], 1'b0);
      $display("t_cirq done");
   endtask : t_cirq

   task automatic close_out();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : close_out

   initial begin
      repeat (20000) @(posedge sys_clk);
      error_cnt++;
      close_out();
   end

   initial begin
      srst            = 1'b1;
      hsel            = 1'b0;
      htrans          = 2'b00;
      haddr           = 32'h0;
      hwrite          = 1'b0;
      hsize           = 3'h2;
      hwdata          = 32'h0;
      timer_count     = 16'h0;
      supervisor_flag = 1'b0;
      ext_lvl         = 3'h7;
      error_cnt       = 0;
      compares        = 0;
      repeat (20) @(posedge sys_clk);
      srst <= 1'b0;
      t_reset();
      t_pins();
      t_tin();
      t_tout();
      t_tgl();
      t_wdog();
      t_cirq();
      close_out();
   end
endmodule : tb_top
